// ### src/bbtx_pkg.sv
// Register map, field positions and timing constants of the transmit configuration bank
package bbtx_pkg;
    // Printed offsets are not all multiples of four: each is an index, byte address is four times it
    localparam logic [7:0] IDX_PART_VERSION_ID = 8'h00;
    localparam logic [7:0] IDX_IO_POLARITY = 8'h02;
    localparam logic [7:0] IDX_I_COVER_CODE = 8'h04;
    localparam logic [7:0] IDX_Q_COVER_CODE = 8'h06;
    localparam logic [7:0] IDX_TX_PREAMBLE_LENGTH = 8'h08;
    localparam logic [7:0] IDX_TX_SIGNAL_FIELD = 8'h0a;
    localparam logic [7:0] IDX_TX_SERVICE_FIELD = 8'h0c;
    localparam logic [7:0] IDX_TX_LENGTH_HIGH = 8'h0e;
    localparam logic [7:0] IDX_TX_LENGTH_LOW = 8'h10;
    localparam logic [7:0] IDX_TX_CONFIGURE = 8'h12;
    localparam logic [7:0] IDX_LAST = 8'h12;
    localparam int ADDR_W = 8;
    // Identity fields; values are arbitrary
    localparam logic [3:0] PART_CODE = 4'ha;
    localparam logic [3:0] VERSION_CODE = 4'h5;
    // Reset values
    localparam logic [7:0] RST_POLARITY = 8'h00;
    localparam logic [7:0] RST_COVER = 8'h48;
    localparam logic [7:0] RST_PREAMBLE = 8'h80;
    localparam logic [7:0] RST_ZERO = 8'h00;
    // Polarity bits
    localparam int POL_RX_Q = 7;
    localparam int POL_TX_Q = 6;
    localparam int POL_TRANSMIT_CLOCK_OUT = 5;
    localparam int POL_TXRDY = 4;
    localparam int POL_TXEN = 3;
    localparam int POL_CCA = 2;
    localparam int POL_MDV = 1;
    localparam int POL_RXCLK = 0;
    // Signal field bits
    localparam int SIG_SHORT = 3;
    localparam int SIG_RATE_HI = 1;
    localparam int SIG_RATE_LO = 0;
    // Transmit configure bits
    localparam int CFG_CCA_TIME = 7;
    localparam int CFG_CCA_HI = 6;
    localparam int CFG_CCA_LO = 5;
    localparam int CFG_TEST_SEL = 4;
    localparam int CFG_TEST_EN = 3;
    localparam int CFG_ANT_VAL = 2;
    localparam int CFG_ANT_MODE = 1;
    // Preamble ramp and timing
    localparam logic [8:0] PA_RAMP_SYMBOLS = 9'h002;
    localparam int CLK_MHZ = 125;
    localparam int CCA_LONG_NS = 19900;
    localparam int CCA_SHORT_NS = 15800;
    localparam logic [11:0] CCA_LONG_CYC = 12'((CCA_LONG_NS * CLK_MHZ) / 1000);
    localparam logic [11:0] CCA_SHORT_CYC = 12'((CCA_SHORT_NS * CLK_MHZ) / 1000);
    // CCA source modes
    localparam logic [1:0] CCA_ED = 2'h0;
    localparam logic [1:0] CCA_CS = 2'h1;
    localparam logic [1:0] CCA_AND = 2'h2;
    localparam logic [1:0] CCA_OR = 2'h3;
    typedef enum logic [3:0] {
        BBTX_RATE1 = 4'h1,
        BBTX_RATE2 = 4'h2,
        BBTX_RATE55 = 4'h4,
        BBTX_RATE11 = 4'h8
    } bbtx_rate_t;
    typedef enum logic [1:0] {
        BBTX_IDLE = 2'h1,
        BBTX_ACK = 2'h2
    } bbtx_bus_t;
endpackage : bbtx_pkg

// ### src/bbtx_config_regs.sv
// Transmit configuration register bank with classic Wishbone slave and polarity logic
//
// Implementation choice: register access over Wishbone.
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// [RULE_01] Read-only part and version code
// [RULE_02] Zero polarity gives normal levels
// [RULE_03] Bit 7 inverts received Q
// [RULE_04] Bit 6 inverts transmitted Q
// [RULE_05] Bits 5,0 invert transmit, receive clocks
// [RULE_06] Bit 4 makes transmit-ready active low
// [RULE_07] Bit 3 makes transmit enable active low
// [RULE_08] Bit 2 makes clear-channel active high
// [RULE_09] Bit 1 makes data-valid active low
// [RULE_10] Cover codes read back, nominal 48h
// [RULE_11] Preamble equals count plus two symbols
// [RULE_12] Host writes preamble while transmit idle
// [RULE_13] Signal bit 3 selects short preamble
// [RULE_14] Signal bits 1:0 select rate code
// [RULE_15] Host sets rate 2 us early
// [RULE_16] Host keeps signal bit 2 zero
// [RULE_17] Service field stored only, host sets bits
// [RULE_18] Sixteen-bit length from high, low bytes
// [RULE_19] Bit 7 picks sampled CCA valid time
// [RULE_20] Bits 6:5 choose clear-channel source
// [RULE_21] Bit 3 enables test, bit 4 pattern
// [RULE_22] Antenna pin from bit 2 or last CRC
// [RULE_23] Unused bits store and read back
module bbtx_config_regs (
    input wire logic clk,
    input wire logic srst,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [9:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic wb_err_o,
    input wire logic rxQIn,
    input wire logic txQInt,
    output logic txQOut,
    output logic rxQInt,
    input wire logic txClkInt,
    input wire logic rxClkInt,
    output logic transmit_clock_out,
    output logic rxClkOut,
    input wire logic txReadyInt,
    output logic txReadyPin,
    input wire logic transmit_power_enable,
    output logic txEnableInt,
    input wire logic energy_detect,
    input wire logic carrier_sense_first,
    input wire logic signal_quality_first,
    input wire logic carrier_sense_second,
    input wire logic ccaSampled,
    input wire logic slotStart,
    output logic clear_channel_indication,
    output logic ccaValid,
    input wire logic modemDataValidInt,
    output logic modem_data_valid,
    input wire logic headerCrcOk,
    input wire logic rxAntenna,
    output logic antenna_select_pin,
    output logic [8:0] preambleSymbols,
    output logic shortPreamble,
    output logic [3:0] txRate,
    output logic [15:0] txLengthUs,
    output logic [7:0] iCoverCode,
    output logic [7:0] qCoverCode,
    output logic [7:0] txServiceField,
    output logic [7:0] txSignalField,
    output logic testEnable,
    output logic testContinuousCarrier,
    output logic testAlternatingBits
);

    typedef struct packed {
        logic [7:0] polarity;
        logic [7:0] iCover;
        logic [7:0] qCover;
        logic [7:0] preamble;
        logic [7:0] signalField;
        logic [7:0] service;
        logic [7:0] lenHigh;
        logic [7:0] lenLow;
        logic [7:0] txCfg;
        logic lastAnt;
        logic [11:0] slotCnt;
        logic ccaValid;
        logic [31:0] rdData;
        logic ack;
        logic err;
        bbtx_pkg::bbtx_bus_t busState;
    } bbtx_state_t;

    bbtx_state_t state_q;
    bbtx_state_t state_d;
    logic [7:0] regIndex;
    logic addrHit;
    logic accessReq;
    logic ccaRaw;
    logic ccaLevel;
    logic [1:0] ccaMode;
    logic [11:0] ccaDeadline;
    logic [7:0] readByte;

    // Word-aligned: byte address bits 1:0 ignored, index is the word number
    assign regIndex = wb_adr_i[9:2];
    assign accessReq = wb_cyc_i && wb_stb_i;

    always_comb begin
        addrHit = 1'b1;
        readByte = 8'h00;
        case (regIndex)
            // [RULE_01] fixed identity
            bbtx_pkg::IDX_PART_VERSION_ID: readByte = {bbtx_pkg::PART_CODE, bbtx_pkg::VERSION_CODE};
            bbtx_pkg::IDX_IO_POLARITY: readByte = state_q.polarity;
            // [RULE_10] cover code readback
            bbtx_pkg::IDX_I_COVER_CODE: readByte = state_q.iCover;
            bbtx_pkg::IDX_Q_COVER_CODE: readByte = state_q.qCover;
            bbtx_pkg::IDX_TX_PREAMBLE_LENGTH: readByte = state_q.preamble;
            // [RULE_23] unused bits read back
            bbtx_pkg::IDX_TX_SIGNAL_FIELD: readByte = state_q.signalField;
            bbtx_pkg::IDX_TX_SERVICE_FIELD: readByte = state_q.service;
            bbtx_pkg::IDX_TX_LENGTH_HIGH: readByte = state_q.lenHigh;
            bbtx_pkg::IDX_TX_LENGTH_LOW: readByte = state_q.lenLow;
            bbtx_pkg::IDX_TX_CONFIGURE: readByte = state_q.txCfg;
            default: addrHit = 1'b0;
        endcase
    end

    // CCA source combine
    assign ccaMode = state_q.txCfg[bbtx_pkg::CFG_CCA_HI:bbtx_pkg::CFG_CCA_LO];
    always_comb begin
        logic csTerm;
        csTerm = carrier_sense_first || signal_quality_first || carrier_sense_second;
        // [RULE_20] source select
        case (ccaMode)
            bbtx_pkg::CCA_ED: ccaRaw = energy_detect;
            bbtx_pkg::CCA_CS: ccaRaw = csTerm;
            bbtx_pkg::CCA_AND: ccaRaw = energy_detect && csTerm;
            bbtx_pkg::CCA_OR: ccaRaw = energy_detect || csTerm;
            default: ccaRaw = energy_detect;
        endcase
    end

    // [RULE_19] sampled result deadline
    assign ccaDeadline = state_q.txCfg[bbtx_pkg::CFG_CCA_TIME] ? bbtx_pkg::CCA_SHORT_CYC : bbtx_pkg::CCA_LONG_CYC;

    always_comb begin
        state_d = state_q;
        state_d.ack = 1'b0;
        state_d.err = 1'b0;
        case (state_q.busState)
            bbtx_pkg::BBTX_IDLE: begin
                if (accessReq) begin
                    state_d.busState = bbtx_pkg::BBTX_ACK;
                    state_d.ack = addrHit;
                    state_d.err = !addrHit;
                    state_d.rdData = {24'h000000, readByte};
                    // Only lane 0 carries data; others ignored
                    if (wb_we_i && addrHit && wb_sel_i[0]) begin
                        case (regIndex)
                            // [RULE_02] polarity store
                            bbtx_pkg::IDX_IO_POLARITY: state_d.polarity = wb_dat_i[7:0];
                            bbtx_pkg::IDX_I_COVER_CODE: state_d.iCover = wb_dat_i[7:0];
                            bbtx_pkg::IDX_Q_COVER_CODE: state_d.qCover = wb_dat_i[7:0];
                            bbtx_pkg::IDX_TX_PREAMBLE_LENGTH: state_d.preamble = wb_dat_i[7:0];
                            // [RULE_23] whole byte stored
                            bbtx_pkg::IDX_TX_SIGNAL_FIELD: state_d.signalField = wb_dat_i[7:0];
                            bbtx_pkg::IDX_TX_SERVICE_FIELD: state_d.service = wb_dat_i[7:0];
                            bbtx_pkg::IDX_TX_LENGTH_HIGH: state_d.lenHigh = wb_dat_i[7:0];
                            bbtx_pkg::IDX_TX_LENGTH_LOW: state_d.lenLow = wb_dat_i[7:0];
                            bbtx_pkg::IDX_TX_CONFIGURE: state_d.txCfg = wb_dat_i[7:0];
                            default: state_d.txCfg = state_q.txCfg;
                        endcase
                    end
                end
            end
            bbtx_pkg::BBTX_ACK: begin
                // Forces one idle cycle so a held stb is not taken twice
                state_d.busState = bbtx_pkg::BBTX_IDLE;
            end
            default: state_d.busState = bbtx_pkg::BBTX_IDLE;
        endcase
        // [RULE_22] remember antenna of last good header
        if (headerCrcOk) begin
            state_d.lastAnt = rxAntenna;
        end
        // Slot timer restarts on each slot boundary
        if (slotStart) begin
            state_d.slotCnt = 12'h000;
            state_d.ccaValid = 1'b0;
        end else if (state_q.slotCnt != 12'hfff) begin
            state_d.slotCnt = state_q.slotCnt + 12'h001;
        end
        if (!slotStart && state_q.slotCnt + 12'h001 == ccaDeadline) begin
            state_d.ccaValid = 1'b1;
        end
        if (srst) begin
            state_d.polarity = bbtx_pkg::RST_POLARITY;
            state_d.iCover = bbtx_pkg::RST_COVER;
            state_d.qCover = bbtx_pkg::RST_COVER;
            state_d.preamble = bbtx_pkg::RST_PREAMBLE;
            state_d.signalField = bbtx_pkg::RST_ZERO;
            state_d.service = bbtx_pkg::RST_ZERO;
            state_d.lenHigh = bbtx_pkg::RST_ZERO;
            state_d.lenLow = bbtx_pkg::RST_ZERO;
            state_d.txCfg = bbtx_pkg::RST_ZERO;
            state_d.lastAnt = 1'b0;
            state_d.slotCnt = 12'h000;
            state_d.ccaValid = 1'b0;
            state_d.rdData = 32'h00000000;
            state_d.ack = 1'b0;
            state_d.err = 1'b0;
            state_d.busState = bbtx_pkg::BBTX_IDLE;
        end
    end

    always_ff @(posedge clk) begin
        state_q <= state_d;
    end

    assign wb_dat_o = state_q.rdData;
    assign wb_ack_o = state_q.ack;
    assign wb_err_o = state_q.err;

    // [RULE_03] receive Q inversion
    assign rxQInt = rxQIn ^ state_q.polarity[bbtx_pkg::POL_RX_Q];
    // [RULE_04] transmit Q inversion
    assign txQOut = txQInt ^ state_q.polarity[bbtx_pkg::POL_TX_Q];
    // [RULE_05] clock phase controls
    assign transmit_clock_out = txClkInt ^ state_q.polarity[bbtx_pkg::POL_TRANSMIT_CLOCK_OUT];
    assign rxClkOut = rxClkInt ^ state_q.polarity[bbtx_pkg::POL_RXCLK];
    // [RULE_06] transmit-ready level
    assign txReadyPin = txReadyInt ^ state_q.polarity[bbtx_pkg::POL_TXRDY];
    // [RULE_07] transmit enable sense
    assign txEnableInt = transmit_power_enable ^ state_q.polarity[bbtx_pkg::POL_TXEN];
    // Sampled result when ccaSampled is high, else live
    assign ccaLevel = ccaSampled ? (ccaRaw && state_q.ccaValid) : ccaRaw;
    // [RULE_08] opposite sense: one is active high
    assign clear_channel_indication = ccaLevel ^ !state_q.polarity[bbtx_pkg::POL_CCA];
    assign ccaValid = state_q.ccaValid;
    // [RULE_09] data-valid level
    assign modem_data_valid = modemDataValidInt ^ state_q.polarity[bbtx_pkg::POL_MDV];
    // [RULE_22] antenna source
    assign antenna_select_pin = state_q.txCfg[bbtx_pkg::CFG_ANT_MODE] ? state_q.lastAnt
                                                                       : state_q.txCfg[bbtx_pkg::CFG_ANT_VAL];

    // [RULE_11] add two-symbol ramp
    assign preambleSymbols = {1'b0, state_q.preamble} + bbtx_pkg::PA_RAMP_SYMBOLS;
    // [RULE_13] preamble format
    assign shortPreamble = state_q.signalField[bbtx_pkg::SIG_SHORT];
    // [RULE_14] rate decode
    always_comb begin
        case (state_q.signalField[bbtx_pkg::SIG_RATE_HI:bbtx_pkg::SIG_RATE_LO])
            2'h0: txRate = bbtx_pkg::BBTX_RATE1;
            2'h1: txRate = bbtx_pkg::BBTX_RATE2;
            2'h2: txRate = bbtx_pkg::BBTX_RATE55;
            default: txRate = bbtx_pkg::BBTX_RATE11;
        endcase
    end
    // [RULE_18] length assembly
    assign txLengthUs = {state_q.lenHigh, state_q.lenLow};
    assign iCoverCode = state_q.iCover;
    assign qCoverCode = state_q.qCover;
    assign txServiceField = state_q.service;
    assign txSignalField = state_q.signalField;
    // [RULE_21] test pattern selection
    assign testEnable = state_q.txCfg[bbtx_pkg::CFG_TEST_EN];
    assign testContinuousCarrier = testEnable && state_q.txCfg[bbtx_pkg::CFG_TEST_SEL];
    assign testAlternatingBits = testEnable && !state_q.txCfg[bbtx_pkg::CFG_TEST_SEL];

endmodule : bbtx_config_regs

`default_nettype wire

// ### testbench/bbtx_checker.sv
// Port assertions for the transmit configuration bank
`timescale 1ns/1ps
`default_nettype none
module bbtx_checker (
    input wire logic clk,
    input wire logic srst,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [9:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic wb_err_o,
    input wire logic rxQIn,
    input wire logic rxQInt,
    input wire logic txQInt,
    input wire logic txQOut,
    input wire logic rxClkInt,
    input wire logic rxClkOut,
    input wire logic transmit_power_enable,
    input wire logic txEnableInt,
    input wire logic antenna_select_pin,
    input wire logic [8:0] preambleSymbols,
    input wire logic slotStart,
    input wire logic ccaValid
);
    typedef struct packed {logic [7:0] pol; logic [7:0] pre; logic [7:0] cfg;} bbtx_shadow_t;
    bbtx_shadow_t shadow_q, shadow_d;
    logic take;
    logic [7:0] idx;
    assign take = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
    assign idx = wb_adr_i[9:2];
    always_comb begin
        shadow_d = shadow_q;
        if (take && wb_we_i && wb_sel_i[0]) begin
            if (idx == bbtx_pkg::IDX_IO_POLARITY) shadow_d.pol = wb_dat_i[7:0];
            if (idx == bbtx_pkg::IDX_TX_PREAMBLE_LENGTH) shadow_d.pre = wb_dat_i[7:0];
            if (idx == bbtx_pkg::IDX_TX_CONFIGURE) shadow_d.cfg = wb_dat_i[7:0];
        end
    end
    always_ff @(posedge clk) begin
        if (srst) shadow_q <= {bbtx_pkg::RST_POLARITY, bbtx_pkg::RST_PREAMBLE, bbtx_pkg::RST_ZERO};
        else shadow_q <= shadow_d;
    end
    // Cycles since the last slot strobe or reset, saturating like a real timer
    logic [11:0] slotAge;
    always_ff @(posedge clk) begin
        if (srst || slotStart) slotAge <= 12'h000;
        else if (slotAge != 12'hfff) slotAge <= slotAge + 12'h001;
    end
    default clocking @(posedge clk); endclocking
    default disable iff (srst);
    a_id_readonly: assert property (
        take && !wb_we_i && idx == bbtx_pkg::IDX_PART_VERSION_ID
        |=> wb_dat_o == {24'h0, bbtx_pkg::PART_CODE, bbtx_pkg::VERSION_CODE}) else $error("id read wrong");
    a_rx_q_sense: assert property (
        rxQInt == (rxQIn ^ shadow_q.pol[7])) else $error("rx Q sense wrong");
    a_tx_q_sense: assert property (
        txQOut == (txQInt ^ shadow_q.pol[6])) else $error("tx Q sense wrong");
    a_rx_clk_phase: assert property (
        rxClkOut == (rxClkInt ^ shadow_q.pol[0])) else $error("rx clock phase wrong");
    a_tx_enable_level: assert property (
        txEnableInt == (transmit_power_enable ^ shadow_q.pol[3])) else $error("tx enable level wrong");
    a_preamble_ramp: assert property (
        preambleSymbols == 9'(shadow_q.pre) + bbtx_pkg::PA_RAMP_SYMBOLS) else $error("preamble count wrong");
    a_antenna_fixed: assert property (
        !shadow_q.cfg[1] |-> antenna_select_pin == shadow_q.cfg[2]) else $error("antenna pin wrong");
    a_cca_valid_time: assert property (
        $rose(ccaValid) |-> slotAge == ($past(shadow_q.cfg[7]) ? bbtx_pkg::CCA_SHORT_CYC : bbtx_pkg::CCA_LONG_CYC))
        else $error("cca valid time wrong");
    a_ack_one_pulse: assert property (
        take && idx <= bbtx_pkg::IDX_LAST && !idx[0] |=> wb_ack_o && !wb_err_o ##1 !wb_ack_o)
        else $error("ack timing wrong");
    c_write_taken: cover property (take && wb_we_i);
    c_unmapped: cover property (wb_err_o);
    c_antenna_latched: cover property (shadow_q.cfg[1]);
    c_cca_valid: cover property ($rose(ccaValid));
endmodule : bbtx_checker
bind bbtx_config_regs bbtx_checker u_chk (.clk(clk), .srst(srst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o), .rxQIn(rxQIn), .rxQInt(rxQInt), .txQInt(txQInt), .txQOut(txQOut),
    .rxClkInt(rxClkInt), .rxClkOut(rxClkOut), .transmit_power_enable(transmit_power_enable),
    .txEnableInt(txEnableInt), .antenna_select_pin(antenna_select_pin), .preambleSymbols(preambleSymbols),
    .slotStart(slotStart), .ccaValid(ccaValid));
`default_nettype wire

// ### testbench/bbtx_host_model.sv
// Host controller model: Wishbone master and transmit enable
`timescale 1ns/1ps
`default_nettype none
module bbtx_host_model (
    input wire logic clk,
    output logic busCyc,
    output logic busStb,
    output logic busWe,
    output logic [9:0] busAdr,
    output logic [3:0] busSel,
    output logic [31:0] busDatW,
    input wire logic [31:0] busDatR,
    input wire logic busAck,
    input wire logic busErr,
    output logic txPowerEnable
);
    logic pol3 = 1'b0;
    logic hold = 1'b0;
    initial begin
        {busCyc, busStb, busWe, busAdr, busSel, busDatW, txPowerEnable} = '0;
    end
    always @(posedge clk) txPowerEnable <= hold ? pol3 : 1'($urandom);
    task automatic access(input logic we, input logic [7:0] idx, input logic [3:0] sel, input logic [7:0] d,
        output logic [31:0] rd, output logic er);
        hold <= we && (idx inside {bbtx_pkg::IDX_I_COVER_CODE, bbtx_pkg::IDX_Q_COVER_CODE,
            bbtx_pkg::IDX_TX_PREAMBLE_LENGTH, bbtx_pkg::IDX_TX_SIGNAL_FIELD});
        @(posedge clk);
        busCyc <= 1'b1;
        busStb <= 1'b1;
        busWe <= we;
        busAdr <= {idx, 2'b00};
        busSel <= sel;
        busDatW <= {24'h0, (idx == bbtx_pkg::IDX_TX_SIGNAL_FIELD) ? d & 8'hfb :
            (idx == bbtx_pkg::IDX_TX_SERVICE_FIELD) ? d & 8'h84 : d};
        do @(posedge clk); while (!(busAck || busErr));
        rd = busDatR;
        er = busErr;
        busCyc <= 1'b0;
        busStb <= 1'b0;
        // Inactive enable level follows its polarity bit
        if (we && sel[0] && idx == bbtx_pkg::IDX_IO_POLARITY) pol3 = d[3];
    endtask : access
endmodule : bbtx_host_model
`default_nettype wire

// ### testbench/baseband_tx_config_regs_tb.sv
// Self-checking bench for the transmit configuration bank
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin numErrors++; \
    $display("[ERR] %0t got %h expected %h", $time, a, b); end end
module baseband_tx_config_regs_tb;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, wb_err_o, transmit_power_enable;
    logic [9:0] wb_adr_i;
    logic [3:0] wb_sel_i, txRate;
    logic [31:0] wb_dat_i, wb_dat_o;
    logic [13:0] dp = 14'h0;
    logic rxQInt, txQOut, transmit_clock_out, rxClkOut, txReadyPin, txEnableInt, clear_channel_indication;
    logic ccaValid, modem_data_valid, antenna_select_pin, shortPreamble, testEnable, testContinuousCarrier;
    logic testAlternatingBits;
    logic [8:0] preambleSymbols;
    logic [15:0] txLengthUs;
    logic [7:0] iCoverCode, qCoverCode, txServiceField, txSignalField;
    logic [7:0] sh [0:9] = '{{bbtx_pkg::PART_CODE, bbtx_pkg::VERSION_CODE}, 8'h00, 8'h48, 8'h48, 8'h80,
        8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    int numErrors = 0;
    int checks = 0;
    int cycles = 0;
    initial forever #4 clk = ~clk;
    // Slot strobe held off early so the sampled-CCA timer can expire once
    always @(posedge clk) dp <= (14'($urandom) & 14'h3bff) | ((cycles > 2600 && $urandom % 512 == 0) ? 14'h0400 : 14'h0000);
    logic antExp = 1'b0;
    always @(posedge clk) antExp <= srst ? 1'b0 : (dp[12] ? dp[13] : antExp);
    bbtx_host_model host (.clk(clk), .busCyc(wb_cyc_i), .busStb(wb_stb_i), .busWe(wb_we_i), .busAdr(wb_adr_i),
        .busSel(wb_sel_i), .busDatW(wb_dat_i), .busDatR(wb_dat_o), .busAck(wb_ack_o), .busErr(wb_err_o),
        .txPowerEnable(transmit_power_enable));
    bbtx_config_regs DUT (.clk(clk), .srst(srst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
        .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .wb_err_o(wb_err_o), .rxQIn(dp[0]), .txQInt(dp[1]), .txQOut(txQOut), .rxQInt(rxQInt), .txClkInt(dp[2]),
        .rxClkInt(dp[3]), .transmit_clock_out(transmit_clock_out), .rxClkOut(rxClkOut), .txReadyInt(dp[4]),
        .txReadyPin(txReadyPin), .transmit_power_enable(transmit_power_enable), .txEnableInt(txEnableInt),
        .energy_detect(dp[5]), .carrier_sense_first(dp[6]), .signal_quality_first(dp[7]),
        .carrier_sense_second(dp[8]), .ccaSampled(dp[9]), .slotStart(dp[10]),
        .clear_channel_indication(clear_channel_indication), .ccaValid(ccaValid), .modemDataValidInt(dp[11]),
        .modem_data_valid(modem_data_valid), .headerCrcOk(dp[12]), .rxAntenna(dp[13]),
        .antenna_select_pin(antenna_select_pin), .preambleSymbols(preambleSymbols), .shortPreamble(shortPreamble),
        .txRate(txRate), .txLengthUs(txLengthUs), .iCoverCode(iCoverCode), .qCoverCode(qCoverCode),
        .txServiceField(txServiceField), .txSignalField(txSignalField), .testEnable(testEnable),
        .testContinuousCarrier(testContinuousCarrier), .testAlternatingBits(testAlternatingBits));
    function automatic logic [3:0] exp_rate(input logic [1:0] code);
        return 4'h1 << code;
    endfunction : exp_rate
    function automatic logic exp_cca(input logic [1:0] mode, input logic ed, input logic cs);
        case (mode)
            2'h0: return ed;
            2'h1: return cs;
            2'h2: return ed & cs;
            default: return ed | cs;
        endcase
    endfunction : exp_cca
    task automatic stop_test();
        if (numErrors == 0 && checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : stop_test
    task automatic acc(input logic we, input int k, input logic [7:0] d, input logic [3:0] sel);
        logic [31:0] rd;
        logic er;
        host.access(we, 8'(2 * k), sel, d, rd, er);
        `CHK(er, 1'(k > 9))
        if (k <= 9 && !we) `CHK(rd, {24'h0, sh[k]})
        if (k <= 9 && we && sel[0] && k != 0) sh[k] = (k == 5) ? d & 8'hfb : (k == 6) ? d & 8'h84 : d;
        `CHK(preambleSymbols, 9'(sh[4]) + 9'h002)
        `CHK({iCoverCode, qCoverCode}, {sh[2], sh[3]})
        `CHK(shortPreamble, sh[5][3])
        `CHK(txRate, exp_rate(sh[5][1:0]))
        `CHK({txServiceField, txSignalField}, {sh[6], sh[5]})
        `CHK(txLengthUs, {sh[7], sh[8]})
        `CHK({testContinuousCarrier, testAlternatingBits}, {sh[9][3] & sh[9][4], sh[9][3] & ~sh[9][4]})
        `CHK(testEnable, sh[9][3])
        `CHK(transmit_clock_out, dp[2] ^ sh[1][5])
        `CHK(txReadyPin, dp[4] ^ sh[1][4])
        `CHK(modem_data_valid, dp[11] ^ sh[1][1])
        `CHK(antenna_select_pin, sh[9][1] ? antExp : sh[9][2])
        if (!dp[9]) `CHK(clear_channel_indication, (exp_cca(sh[9][6:5], dp[5], dp[6] | dp[7] | dp[8]) ~^ sh[1][2]))
    endtask : acc
    // Hang guard, well above the expected run
    always @(posedge clk) begin
        cycles++;
        if (cycles == 10000) begin
            numErrors++;
            stop_test();
        end
    end
    initial begin
        void'($urandom(91620));
        repeat (2) @(posedge clk);
        srst <= 1'b0;
        for (int k = 0; k < 10; k++) acc(1'b0, k, 8'h00, 4'hf);
        acc(1'b1, 0, 8'hff, 4'hf);
        acc(1'b1, 4, 8'h80, 4'hf);
        for (int r = 0; r < 4; r++) acc(1'b1, 5, 8'(r), 4'hf);
        repeat (1000) acc(1'($urandom), int'($urandom % 16), 8'($urandom), ($urandom % 8 == 0) ? 4'he : 4'hf);
        // Mid-run reset must bring every register back
        srst <= 1'b1;
        repeat (2) @(posedge clk);
        srst <= 1'b0;
        host.pol3 = 1'b0;
        for (int k = 1; k < 10; k++) sh[k] = (k == 2 || k == 3) ? 8'h48 : (k == 4) ? 8'h80 : 8'h00;
        for (int k = 0; k < 10; k++) acc(1'b0, k, 8'h00, 4'hf);
        stop_test();
    end
endmodule : baseband_tx_config_regs_tb
`default_nettype wire
